// ### hdl/bcb_top.sv
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// Notes on behaviour
// - power-good only above 95% of target
// - power-good deglitched over 200 us
// - error latches if no power-good after 10 ms
// - power-good reads low while boost off
// - enable or charge runs boost unless sleeping-off
// - low-supply request plus comparator enables boost
// - regulator fault state always enables boost
// - charge bit self-clears on power-good
// - switch on to peak, off until zero current
// - no switching above regulation voltage
// - inactivity timer flags after programmed limit
// - peak current resets to 500 mA setting
// - soft start lowers peak below 3 V, except at the 2.7 V target once power-good
// - oscillator on with boost or amp enable bits
// - bias on when any connected block enabled; boost run only by charge or low-supply leaves it off
// - fault state forces boost and overtemp monitor
module bcb_top (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic      [31:0] rdata,
	input  wire logic        above_target,
	input  wire logic        above_95,
	input  wire logic        below_3v,
	input  wire logic        ipk_reached,
	input  wire logic        izero,
	input  wire logic        low_supply_comparator,
	input  wire logic        controller_regulator_fault,
	input  wire logic        led_pulse_pin,
	output logic             switch_node,
	output logic             boost_on,
	output logic      [3:0]  peak_current,
	output logic      [3:0]  output_target_setting,
	output logic             osc_enable,
	output logic             bias_enable,
	output logic             overtemp_monitor_on,
	output logic             irq
);
	typedef enum logic [1:0] {SW_IDLE, SW_ON, SW_OFF} bcb_sw_t;

	typedef struct packed {
		bcb_pkg::bcb_regs_t regs;
		bcb_sw_t            sw;
		logic               gate;
		logic               pg_raw;
		logic [13:0]        dgl_cnt;
		logic               pg;
		logic               en_d;
		logic               win_clr;
		logic               switched;
		logic               inact_d;
		logic [31:0]        rdata;
		logic               boost_on;
		logic [3:0]         ipk;
		logic               osc;
		logic               bias;
		logic               ots;
		logic               irq;
	} bcb_state_t;

	bcb_state_t st_r;
	bcb_state_t st_nxt;

	bcb_pkg::bcb_analog_t ana_in;
	bcb_pkg::bcb_analog_t ana;
	logic [7:0] ana_q;
	logic       win_done;
	logic       inact_done;
	logic [9:0]  inact_code;
	logic [21:0] inact_lim;

	// comparator levels arrive asynchronous to clk
	assign ana_in.above_target = above_target;
	assign ana_in.above_95     = above_95;
	assign ana_in.below_3v     = below_3v;
	assign ana_in.ipk_reached  = ipk_reached;
	assign ana_in.izero        = izero;
	assign ana_in.low_supply   = low_supply_comparator;
	assign ana_in.ldo_fault    = controller_regulator_fault;
	assign ana_in.led_pin      = led_pulse_pin;

	// two stages before any logic reads a comparator
	bcb_sync u_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.d       (ana_in),
		.q       (ana_q)
	);
	assign ana = ana_q;

	// good window runs while enabled and not yet good
	bcb_timer #(.W(20)) u_win (
		.clk     (clk),
		.reset_n (reset_n),
		.run     (st_r.boost_on && !st_r.pg),
		.clr     (st_r.win_clr),
		.limit   (20'(bcb_pkg::PG_WIN_CYC - 1)),
		.done    (win_done)
	);

	// codes past 999 would run beyond 100 ms, so they saturate
	assign inact_code = (st_r.regs.setup[bcb_pkg::SET_INACT_LSB +: 10] > bcb_pkg::INACT_RST)
		? bcb_pkg::INACT_RST
		: st_r.regs.setup[bcb_pkg::SET_INACT_LSB +: 10];

	// limit = (code+1) * 100 us, code 0..999 spans 100 us..100 ms
	// 100 ms is 4_000_000 cycles, hence the 22-bit counter
	assign inact_lim = 22'(
		(int'(inact_code) + 1) * bcb_pkg::INACT_STEP_CYC - 1);

	bcb_timer #(.W(22)) u_inact (
		.clk     (clk),
		.reset_n (reset_n),
		.run     (st_r.boost_on),
		.clr     (st_r.switched),
		.limit   (inact_lim),
		.done    (inact_done)
	);

	always_comb begin
		logic [bcb_pkg::CTRL_W-1:0] c;
		logic en;
		logic ctl_en;
		logic err_set;
		logic inact_set;
		logic pg_set;
		logic [bcb_pkg::ST_W-1:0] set_v;
		logic [bcb_pkg::ST_W-1:0] clr_v;
		logic [3:0] vsel;
		logic [3:0] ipk_reg;
		logic sleep_off;
		c = '0;
		en = 1'b0;
		ctl_en = 1'b0;
		err_set = 1'b0;
		inact_set = 1'b0;
		pg_set = 1'b0;
		set_v = '0;
		clr_v = '0;
		vsel = '0;
		ipk_reg = '0;
		sleep_off = 1'b0;
		st_nxt = st_r;
		st_nxt.win_clr = 1'b0;
		st_nxt.switched = 1'b0;
		st_nxt.rdata = '0;
		c = st_r.regs.ctrl;

		// register writes
		if (wr_en) begin
			case (addr)
				bcb_pkg::ADDR_CTRL: begin
					st_nxt.regs.ctrl = wdata[bcb_pkg::CTRL_W-1:0];
				end
				bcb_pkg::ADDR_SETUP: begin
					st_nxt.regs.setup = wdata[bcb_pkg::SET_W-1:0];
					if (wdata[bcb_pkg::SET_VSEL_LSB +: 4] !=
						st_r.regs.setup[bcb_pkg::SET_VSEL_LSB +: 4]) begin
						st_nxt.win_clr = 1'b1;
					end
				end
				bcb_pkg::ADDR_STATUS: begin
					clr_v = wdata[bcb_pkg::ST_W-1:0];
				end
				bcb_pkg::ADDR_MASK: begin
					st_nxt.regs.mask = wdata[bcb_pkg::ST_W-1:0];
				end
				default: begin
					// unmapped writes are dropped
				end
			endcase
		end

		// read-to-clear of the error latch
		// rdata takes the value from before the clear
		if (rd_en && addr == bcb_pkg::ADDR_STATUS) begin
			clr_v[bcb_pkg::ST_ERR] = 1'b1;
		end

		// effective enable
		sleep_off = c[bcb_pkg::CTRL_SLEEP_BOOST_OFF] && c[bcb_pkg::CTRL_SLP_ACT];
		ctl_en = (c[bcb_pkg::CTRL_BOOST_ENABLE_BIT] || c[bcb_pkg::CTRL_CHARGE])
			&& !sleep_off;
		// regulator fault ignores the sleep bits
		en = ctl_en
			|| (c[bcb_pkg::CTRL_LOW_REQ] && ana.low_supply)
			|| ana.ldo_fault;
		st_nxt.boost_on = en;
		st_nxt.en_d = en;
		if (en && !st_r.en_d) begin
			st_nxt.win_clr = 1'b1;
		end

		// power-good deglitch
		// a level must hold the whole window to be taken
		st_nxt.pg_raw = ana.above_95 && en;
		if (!en) begin
			st_nxt.pg = 1'b0;
			st_nxt.dgl_cnt = '0;
		end else if (st_r.pg_raw == st_r.pg) begin
			st_nxt.dgl_cnt = '0;
		end else if (st_r.dgl_cnt >= 14'(bcb_pkg::PG_DGL_CYC - 1)) begin
			st_nxt.pg = st_r.pg_raw;
			st_nxt.dgl_cnt = '0;
		end else begin
			st_nxt.dgl_cnt = st_r.dgl_cnt + 14'h0001;
		end

		// one-shot charge clears once power-good
		// dropping it also drops the boost next cycle
		if (st_r.pg && st_r.regs.ctrl[bcb_pkg::CTRL_CHARGE]) begin
			st_nxt.regs.ctrl[bcb_pkg::CTRL_CHARGE] = 1'b0;
		end

		// hysteretic switch control
		case (st_r.sw)
			SW_IDLE: begin
				if (st_r.boost_on && !ana.above_target) begin
					st_nxt.sw = SW_ON;
					st_nxt.switched = 1'b1;
				end
			end
			SW_ON: begin
				// boost dropped mid-pulse, open at once
				if (!st_r.boost_on) begin
					st_nxt.sw = SW_IDLE;
				end else if (ana.ipk_reached) begin
					st_nxt.sw = SW_OFF;
				end
			end
			SW_OFF: begin
				// open until the inductor has emptied
				if (ana.izero) begin
					st_nxt.sw = SW_IDLE;
				end
			end
			default: begin
				st_nxt.sw = SW_IDLE;
			end
		endcase

		// gate comes straight from its own flop
		st_nxt.gate = (st_nxt.sw == SW_ON);

		// peak current with soft start
		// reduced peak while the output is still low
		vsel = st_r.regs.setup[bcb_pkg::SET_VSEL_LSB +: 4];
		ipk_reg = st_r.regs.setup[bcb_pkg::SET_IPK_LSB +: 4];
		if (st_r.boost_on && ana.below_3v
			&& !(vsel == bcb_pkg::VSEL_2V7 && st_r.pg)) begin
			st_nxt.ipk = (ipk_reg < bcb_pkg::IPK_SOFT) ? ipk_reg : bcb_pkg::IPK_SOFT;
		end else begin
			st_nxt.ipk = ipk_reg;
		end

		// oscillator and bias
		st_nxt.osc = c[bcb_pkg::CTRL_BOOST_ENABLE_BIT] || c[bcb_pkg::CTRL_PAMP];
		st_nxt.ots = c[bcb_pkg::CTRL_OTS] || ana.ldo_fault;
		// bias follows every block that hangs off it, except boost run only by charge or low-supply
		st_nxt.bias = c[bcb_pkg::CTRL_PAMP]
			|| c[bcb_pkg::CTRL_BOOST_ENABLE_BIT]
			|| c[bcb_pkg::CTRL_HORN]
			|| c[bcb_pkg::CTRL_LEDLDO]
			|| c[bcb_pkg::CTRL_PGAIN]
			|| c[bcb_pkg::CTRL_BATT]
			|| c[bcb_pkg::CTRL_OTS]
			|| ana.ldo_fault
			|| (c[bcb_pkg::CTRL_AMUX_LSB +: 3] != 3'h0)
			|| (ana.led_pin && c[bcb_pkg::CTRL_LEDGATE]);

		// sticky status, set wins over clear
		err_set = win_done && st_r.boost_on && !st_r.pg;
		inact_set = inact_done && !st_r.inact_d;
		st_nxt.inact_d = inact_done;
		pg_set = st_r.pg;
		set_v = '0;
		set_v[bcb_pkg::ST_ERR] = err_set;
		set_v[bcb_pkg::ST_INACT] = inact_set;
		st_nxt.regs.status = (st_r.regs.status & ~clr_v) | set_v;
		// pg bit is live and read-only
		st_nxt.regs.status[bcb_pkg::ST_PG] = pg_set;
		// live power-good bit never raises the interrupt
		st_nxt.irq = (st_nxt.regs.status[bcb_pkg::ST_ERR]
			&& st_nxt.regs.mask[bcb_pkg::ST_ERR])
			|| (st_nxt.regs.status[bcb_pkg::ST_INACT]
			&& st_nxt.regs.mask[bcb_pkg::ST_INACT]);

		// read data
		if (rd_en) begin
			case (addr)
				bcb_pkg::ADDR_CTRL: begin
					st_nxt.rdata = 32'(st_r.regs.ctrl);
				end
				bcb_pkg::ADDR_SETUP: begin
					st_nxt.rdata = 32'(st_r.regs.setup);
				end
				bcb_pkg::ADDR_STATUS: begin
					st_nxt.rdata = 32'(st_r.regs.status);
				end
				bcb_pkg::ADDR_MASK: begin
					st_nxt.rdata = 32'(st_r.regs.mask);
				end
				bcb_pkg::ADDR_STATE: begin
					st_nxt.rdata = 32'({st_r.ipk, st_r.bias, st_r.osc, st_r.boost_on});
				end
				default: begin
					// unmapped words read as zero
					st_nxt.rdata = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
			st_r.regs.ctrl <= bcb_pkg::CTRL_RST;
			st_r.regs.setup <= {bcb_pkg::INACT_RST, bcb_pkg::IPK_500MA,
				bcb_pkg::VSEL_RST};
			st_r.sw <= SW_IDLE;
			// peak starts at the 500 mA code
			st_r.ipk <= bcb_pkg::IPK_500MA;
		end else begin
			st_r <= st_nxt;
		end
	end

	// every output is a flop
	assign rdata = st_r.rdata;
	assign switch_node = st_r.gate;
	assign boost_on = st_r.boost_on;
	assign peak_current = st_r.ipk;
	assign output_target_setting = st_r.regs.setup[bcb_pkg::SET_VSEL_LSB +: 4];
	assign osc_enable = st_r.osc;
	assign bias_enable = st_r.bias;
	assign overtemp_monitor_on = st_r.ots;
	assign irq = st_r.irq;
endmodule

// ### hdl/bcb_pkg.sv
package bcb_pkg;

	// register indices (word addresses, byte address = 4 * index)
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_SETUP  = 8'h01;
	localparam logic [7:0] ADDR_STATUS = 8'h02;
	localparam logic [7:0] ADDR_MASK   = 8'h03;
	localparam logic [7:0] ADDR_STATE  = 8'h04;

	// control field positions
	localparam int CTRL_BOOST_ENABLE_BIT   = 0;
	localparam int CTRL_CHARGE   = 1;
	localparam int CTRL_SLEEP_BOOST_OFF  = 2;
	localparam int CTRL_SLP_ACT  = 3;
	localparam int CTRL_LOW_REQ  = 4;
	localparam int CTRL_PAMP     = 5;
	localparam int CTRL_HORN     = 6;
	localparam int CTRL_LEDLDO   = 7;
	localparam int CTRL_PGAIN    = 8;
	localparam int CTRL_BATT     = 9;
	localparam int CTRL_OTS      = 10;
	localparam int CTRL_LEDGATE  = 11;
	localparam int CTRL_AMUX_LSB = 12;
	localparam int CTRL_W        = 15;

	// setup field layout
	localparam int SET_VSEL_LSB  = 0;
	localparam int SET_IPK_LSB   = 4;
	localparam int SET_INACT_LSB = 8;
	localparam int SET_W         = 18;

	// status bits
	localparam int ST_ERR   = 0;
	localparam int ST_INACT = 1;
	localparam int ST_PG    = 2;
	localparam int ST_W     = 3;

	// reset values, soft-start peak and 2.7 V target codes
	localparam logic [CTRL_W-1:0] CTRL_RST = 15'h0000;
	localparam logic [3:0] VSEL_RST  = 4'h0;
	localparam logic [3:0] IPK_500MA = 4'hF;
	localparam logic [3:0] IPK_SOFT  = 4'h3;
	localparam logic [3:0] VSEL_2V7  = 4'h0;
	localparam logic [9:0] INACT_RST = 10'h3E7;

	// timing
	localparam int CLK_HZ       = 40_000_000;
	localparam int PG_DGL_US    = 200;
	localparam int PG_WIN_MS    = 10;
	localparam int INACT_STEP_US = 100;
	localparam int PG_DGL_CYC   = PG_DGL_US * (CLK_HZ / 1_000_000);
	localparam int PG_WIN_CYC   = PG_WIN_MS * (CLK_HZ / 1_000);
	localparam int INACT_STEP_CYC = INACT_STEP_US * (CLK_HZ / 1_000_000);

	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [SET_W-1:0]  setup;
		logic [ST_W-1:0]   status;
		logic [ST_W-1:0]   mask;
	} bcb_regs_t;

	typedef struct packed {
		logic above_target;
		logic above_95;
		logic below_3v;
		logic ipk_reached;
		logic izero;
		logic low_supply;
		logic ldo_fault;
		logic led_pin;
	} bcb_analog_t;

endpackage

// ### hdl/bcb_sync.sv
`timescale 1ns/1ps
module bcb_sync (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic [7:0] d,
	output logic      [7:0] q
);
	typedef struct packed {
		logic [7:0] s1;
		logic [7:0] s2;
	} bcb_sync_t;

	bcb_sync_t st_r;
	bcb_sync_t st_nxt;

	always_comb begin
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.s2;
endmodule

// ### hdl/bcb_timer.sv
`timescale 1ns/1ps
// counts while run is high, restarts on clr or !run, done when count hits limit
module bcb_timer #(
	parameter int W = 20
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic         run,
	input  wire logic         clr,
	input  wire logic [W-1:0] limit,
	output logic              done
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         done;
	} bcb_tmr_t;

	bcb_tmr_t st_r;
	bcb_tmr_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (clr || !run) begin
			st_nxt.cnt = '0;
			st_nxt.done = 1'b0;
		end else if (st_r.cnt >= limit) begin
			st_nxt.done = 1'b1;
		end else begin
			st_nxt.cnt = st_r.cnt + W'(1);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign done = st_r.done;
endmodule

// ### tb/bcb_monitor.sv
`timescale 1ns/1ps
module bcb_monitor (
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic       above_target,
	input wire logic       above_95,
	input wire logic       below_3v,
	input wire logic       ipk_reached,
	input wire logic       controller_regulator_fault,
	input wire logic       switch_node,
	input wire logic       boost_on,
	input wire logic [3:0] peak_current,
	input wire logic       osc_enable,
	input wire logic       bias_enable,
	input wire logic       overtemp_monitor_on
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_osc_bias: assert property (osc_enable |-> bias_enable)
		else $error("osc without bias");
	a_no_sw_above: assert property (above_target [*5] |-> !$rose(switch_node))
		else $error("switching above target");
	a_sw_off_peak: assert property ($rose(ipk_reached) |-> ##[1:4] !switch_node)
		else $error("switch held past peak");
	a_peak_reset: assert property ($rose(reset_n) |-> peak_current == 4'hF)
		else $error("peak not full after reset");
	a_peak_soft: assert property ((boost_on && below_3v && !above_95) [*6]
		|-> peak_current == bcb_pkg::IPK_SOFT)
		else $error("no soft start peak");
	a_fault_boost: assert property (controller_regulator_fault [*6] |-> boost_on)
		else $error("fault without boost");
	a_fault_ovt: assert property (controller_regulator_fault [*6] |-> overtemp_monitor_on)
		else $error("fault without overtemp");
	a_off_idle: assert property (!boost_on [*4] |-> !switch_node)
		else $error("switching while off");
endmodule
bind bcb_top bcb_monitor bcb_monitor_i (.clk, .reset_n, .above_target, .above_95, .below_3v,
	.ipk_reached, .controller_regulator_fault, .switch_node, .boost_on, .peak_current,
	.osc_enable, .bias_enable, .overtemp_monitor_on);

// ### tb/bcb_plant.sv
`timescale 1ns/1ps
module bcb_plant #(
	parameter int D = 3
) (
	input  wire logic clk,
	input  wire logic switch_node,
	output logic      ipk_reached,
	output logic      izero
);
	int   n = 0;
	logic p = 0;
	initial ipk_reached = 0;
	initial izero = 1;
	// current ramps up while on, down while off
	always @(posedge clk) begin
		n = (switch_node === p) ? n + 1 : 0;
		p = switch_node;
		ipk_reached <= switch_node && n >= D;
		izero <= !switch_node && n >= D;
	end
endmodule

// ### tb/bcb_top_tb_top.sv
`timescale 1ns/1ps
module bcb_top_tb_top;
	logic        clk, reset_n, wr_en, rd_en, p;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, d;
	logic        above_target, above_95, below_3v, ipk_reached, izero;
	logic        low_supply_comparator, controller_regulator_fault, led_pulse_pin;
	logic        switch_node, boost_on, osc_enable, bias_enable, overtemp_monitor_on, irq;
	logic [3:0]  peak_current, output_target_setting;
	int          err_total, compares, k;

	bcb_top bcb_top_i (.clk, .reset_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .above_target,
		.above_95, .below_3v, .ipk_reached, .izero, .low_supply_comparator,
		.controller_regulator_fault, .led_pulse_pin, .switch_node, .boost_on, .peak_current,
		.output_target_setting, .osc_enable, .bias_enable, .overtemp_monitor_on, .irq);
	bcb_plant bcb_plant_i (.clk, .switch_node, .ipk_reached, .izero);

	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end

	task conclude;
		if (err_total == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	task rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		d = rdata;
	endtask

	task wboost(input logic v);
		for (int i = 0; i < 20000 && boost_on !== v; i++)
			wt(1);
	endtask

	task t_regs;
		wr(8'h07, 32'hFFFF_FFFF);
		rd(8'h01);
		chk(d, 32'h0003_E7F0);
		chk(peak_current, 4'hF);
		wr(8'h01, 32'h0003_E7F5);
		wt(2);
		chk(output_target_setting, 4'h5);
		wr(8'h01, 32'h0003_E7F0);
		wt(2);
		chk(output_target_setting, 4'h0);
	endtask

	task t_bias;
		for (int i = 5; i < 13; i++) begin
			wr(8'h00, 32'h1 << i);
			wt(6);
			chk({bias_enable, osc_enable}, {i != 11, i == 5});
		end
		wr(8'h00, 32'h800);
		led_pulse_pin <= 1'b1;
		wt(8);
		chk(bias_enable, 1'b1);
		wr(8'h00, 32'h21);
		wr(8'h00, 32'h1);
		led_pulse_pin <= 1'b0;
		wt(6);
		chk({bias_enable, osc_enable, boost_on}, 3'h7);
		wr(8'h00, 32'hD);
		wt(6);
		chk({osc_enable, boost_on}, 2'h2);
		wr(8'h00, 32'h9);
		wt(6);
		chk(boost_on, 1'b1);
		wr(8'h00, 32'h0);
	endtask

	task t_low;
		wr(8'h00, 32'h10);
		wt(6);
		chk(boost_on, 1'b0);
		wr(8'h00, 32'h10);
		low_supply_comparator <= 1'b1;
		wboost(1'b1);
		chk(boost_on, 1'b1);
		wr(8'h00, 32'h0);
		low_supply_comparator <= 1'b0;
		wboost(1'b0);
	endtask

	task t_fault;
		wr(8'h00, 32'hC);
		controller_regulator_fault <= 1'b1;
		wt(8);
		chk({boost_on, overtemp_monitor_on, bias_enable}, 3'h7);
		wr(8'h00, 32'h0);
		controller_regulator_fault <= 1'b0;
		wboost(1'b0);
	endtask

	task t_sw;
		wr(8'h00, 32'h1);
		above_target <= 1'b0;
		below_3v <= 1'b1;
		k = 0;
		p = 0;
		repeat (200) begin
			wt(1);
			k += switch_node && !p;
			p = switch_node;
		end
		chk(k > 3, 1'b1);
		chk(peak_current, 4'h3);
		wr(8'h00, 32'h1);
		above_target <= 1'b1;
		below_3v <= 1'b0;
		wt(10);
		k = 0;
		repeat (100) begin
			wt(1);
			k += switch_node;
		end
		chk(k, 0);
		chk(peak_current, 4'hF);
		wr(8'h00, 32'h0);
	endtask

	task t_pg;
		wr(8'h00, 32'h2);
		above_95 <= 1'b1;
		wt(7800);
		chk(boost_on, 1'b1);
		wboost(1'b0);
		chk(boost_on, 1'b0);
		rd(8'h00);
		chk(d[1], 1'b0);
		rd(8'h02);
		chk(d[2], 1'b0);
		wr(8'h00, 32'h1);
		wt(8200);
		rd(8'h02);
		chk(d[2:0], 3'h4);
		below_3v <= 1'b1;
		wt(6);
		chk(peak_current, 4'hF);
		below_3v <= 1'b0;
		wr(8'h00, 32'h0);
		above_95 <= 1'b0;
		wt(10);
		rd(8'h02);
		chk(d[2], 1'b0);
	endtask

	task t_irq;
		wr(8'h01, 32'hF0);
		wr(8'h03, 32'h2);
		wr(8'h00, 32'h1);
		wt(3800);
		chk(irq, 1'b0);
		wt(600);
		chk(irq, 1'b1);
		wr(8'h00, 32'h0);
		wr(8'h03, 32'h0);
		wt(3);
		chk(irq, 1'b0);
		rd(8'h02);
		chk(d[1], 1'b1);
		wr(8'h02, 32'h2);
		rd(8'h02);
		chk(d[1], 1'b0);
	endtask

	initial begin
		reset_n = 0;
		wr_en = 0;
		rd_en = 0;
		addr = 0;
		wdata = 0;
		above_target = 1;
		above_95 = 0;
		below_3v = 0;
		low_supply_comparator = 0;
		controller_regulator_fault = 0;
		led_pulse_pin = 0;
		err_total = 0;
		compares = 0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		t_regs;
		t_bias;
		t_low;
		t_fault;
		t_sw;
		t_pg;
		t_irq;
		conclude;
	end

	initial begin
		#2_000_000;
		err_total++;
		conclude;
	end
endmodule
